// ### verilog/gpio_port_pkg.sv
// Shared constants, register offsets and types of the general-purpose port.
package gpio_port_pkg;

   localparam int NUM_PINS_DEF = 9;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int ALT_FLD_W = 2;
   localparam int CLKDIV_W_DEF = 16;
   localparam int PWM_W_DEF = 16;

   localparam logic [ADDR_W-1:0] OFS_DIR = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_ODRAIN = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_DOUT = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_PIN = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_ALTSEL = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_CLKDIV = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_PWM_PERIOD = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_PWM_DUTY = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_EDGE = 4'h8;

   localparam logic [DATA_W-1:0] DIR_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ODRAIN_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DOUT_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ALTSEL_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] EDGE_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ALT_CAPABLE_DEF = 32'h0000_01F0;

   typedef enum logic [ALT_FLD_W-1:0] {
      ALT_GPIO,
      ALT_GPCLK,
      ALT_PWM,
      ALT_EDGE
   } alt_mode_t;

   typedef struct packed {
      logic dir;
      logic odrain;
      logic data;
      alt_mode_t alt;
   } pin_cfg_t;

endpackage

// ### verilog/gpio_pin_cell.sv
// One pin of the port: output selection, drive mode and input sampling.
`timescale 1ns/100ps
module gpio_pin_cell
   import gpio_port_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pin_cfg_t cfg_i,
   input wire logic gpclk_i,
   input wire logic pwm_i,
   input wire logic pad_in_i,
   output logic pad_out_o,
   output logic pad_oe_o,
   output logic in_o,
   output logic rise_o
);

   logic val;
   logic next_pad_out;
   logic next_pad_oe;
   logic prev_in;

   always_comb begin
      case (cfg_i.alt)
         ALT_GPCLK: val = gpclk_i;
         ALT_PWM: val = pwm_i;
         default: val = cfg_i.data;
      endcase
      if (cfg_i.dir && cfg_i.odrain) begin
         next_pad_out = 1'b0; // R6
         next_pad_oe = ~val; // R6
      end else begin
         next_pad_out = val; // R2
         next_pad_oe = cfg_i.dir; // R1
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pad_out_o <= 1'b0;
         pad_oe_o <= 1'b0; // R4
         in_o <= 1'b1;
         prev_in <= 1'b1;
      end else begin
         pad_out_o <= next_pad_out;
         pad_oe_o <= next_pad_oe;
         in_o <= pad_in_i; // R6
         prev_in <= in_o;
      end
   end

   assign rise_o = in_o & ~prev_in;

   property p_push_pull;
      @(posedge clk_i) disable iff (rst_i)
      cfg_i.dir && !cfg_i.odrain |=> pad_oe_o && pad_out_o == $past(val);
   endproperty
   a_push_pull: assert property (p_push_pull) // R2
      else $error("Push-pull pin not driving its value.");

   property p_open_drain;
      @(posedge clk_i) disable iff (rst_i)
      cfg_i.dir && cfg_i.odrain |=> !pad_out_o && pad_oe_o == !$past(val);
   endproperty
   a_open_drain: assert property (p_open_drain) // R6
      else $error("Open-drain pin drive wrong.");

   property p_input_float;
      @(posedge clk_i) disable iff (rst_i)
      !cfg_i.dir |=> !pad_oe_o;
   endproperty
   a_input_float: assert property (p_input_float) // R1
      else $error("Input pin is being driven.");

endmodule

// ### verilog/gpio_port.sv
// Nine-pin programmable general-purpose port with register access.
//
// Function
// [R1] The port has nine pins, each set by software as input or output.
// [R2] Each output pin is driven push-pull or open-drain as software picks.
// [R3] Selected pins offer alternative functions chosen per pin by software.
// [R4] After reset every pin is an input with its driver off.
// [R5] Reset clears the alternative functions except the clock and PWM.
// [R6] Open-drain drives low for zero, releases for one; level stays readable.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module gpio_port
   import gpio_port_pkg::*;
#(
   parameter int NUM_PINS = NUM_PINS_DEF,
   parameter logic [DATA_W-1:0] ALT_CAPABLE = ALT_CAPABLE_DEF,
   parameter int CLKDIV_W = CLKDIV_W_DEF,
   parameter int PWM_W = PWM_W_DEF
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic [NUM_PINS-1:0] pad_in_i,
   output logic [NUM_PINS-1:0] pad_out_o,
   output logic [NUM_PINS-1:0] pad_oe_o
);

   localparam int SEL_W = NUM_PINS * ALT_FLD_W;

   if (NUM_PINS < 1 || SEL_W > DATA_W) begin : g_bad_pins
      $error("NUM_PINS must lie between 1 and 16.");
   end
   if (CLKDIV_W < 1 || CLKDIV_W > DATA_W) begin : g_bad_clkdiv
      $error("CLKDIV_W must lie between 1 and 32.");
   end
   if (PWM_W < 1 || PWM_W > DATA_W) begin : g_bad_pwm
      $error("PWM_W must lie between 1 and 32.");
   end

   // Configuration registers, cleared by reset.
   logic [NUM_PINS-1:0] dir;
   logic [NUM_PINS-1:0] odrain;
   logic [NUM_PINS-1:0] dout;
   logic [SEL_W-1:0] altsel;
   logic [NUM_PINS-1:0] edge_flag;
   logic [NUM_PINS-1:0] next_dir;
   logic [NUM_PINS-1:0] next_odrain;
   logic [NUM_PINS-1:0] next_dout;
   logic [SEL_W-1:0] next_altsel;
   logic [NUM_PINS-1:0] next_edge_flag;
   logic [DATA_W-1:0] next_rdata;

   // Clock and PWM generators, which keep running through reset.
   logic [CLKDIV_W-1:0] clkdiv;
   logic [CLKDIV_W-1:0] clk_cnt;
   logic gpclk;
   logic [PWM_W-1:0] pwm_period;
   logic [PWM_W-1:0] pwm_duty;
   logic [PWM_W-1:0] pwm_cnt;
   logic pwm;
   logic [CLKDIV_W-1:0] next_clkdiv;
   logic [CLKDIV_W-1:0] next_clk_cnt;
   logic next_gpclk;
   logic [PWM_W-1:0] next_pwm_period;
   logic [PWM_W-1:0] next_pwm_duty;
   logic [PWM_W-1:0] next_pwm_cnt;
   logic next_pwm;

   logic [NUM_PINS-1:0] pin_in;
   logic [NUM_PINS-1:0] pin_rise;
   logic [SEL_W-1:0] sel_mask;
   logic wr_dir;
   logic wr_odrain;
   logic wr_dout;
   logic wr_altsel;
   logic wr_clkdiv;
   logic wr_period;
   logic wr_duty;
   logic wr_edge;

   assign wr_dir = wr_i && addr_i == OFS_DIR;
   assign wr_odrain = wr_i && addr_i == OFS_ODRAIN;
   assign wr_dout = wr_i && addr_i == OFS_DOUT;
   assign wr_altsel = wr_i && addr_i == OFS_ALTSEL;
   assign wr_clkdiv = wr_i && addr_i == OFS_CLKDIV;
   assign wr_period = wr_i && addr_i == OFS_PWM_PERIOD;
   assign wr_duty = wr_i && addr_i == OFS_PWM_DUTY;
   assign wr_edge = wr_i && addr_i == OFS_EDGE;

   // Only pins that offer alternatives may hold a non-zero selection.
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
         pin_cfg_t cfg;
         assign sel_mask[g*ALT_FLD_W +: ALT_FLD_W] =
            ALT_CAPABLE[g] ? 2'h3 : 2'h0; // R3
         assign cfg.dir = dir[g];
         assign cfg.odrain = odrain[g];
         assign cfg.data = dout[g];
         assign cfg.alt = alt_mode_t'(altsel[g*ALT_FLD_W +: ALT_FLD_W]);

         gpio_pin_cell u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cfg_i(cfg),
            .gpclk_i(gpclk),
            .pwm_i(pwm),
            .pad_in_i(pad_in_i[g]),
            .pad_out_o(pad_out_o[g]),
            .pad_oe_o(pad_oe_o[g]),
            .in_o(pin_in[g]),
            .rise_o(pin_rise[g])
         );

         assign next_edge_flag[g] =
            (cfg.alt == ALT_EDGE && pin_rise[g]) ||
            (edge_flag[g] && !(wr_edge && wdata_i[g])); // R3

         property p_edge_set;
            @(posedge clk_i) disable iff (rst_i)
            cfg.alt == ALT_EDGE && pin_rise[g] |=> edge_flag[g];
         endproperty
         a_edge_set: assert property (p_edge_set) // R3
            else $error("Rising edge not captured.");
      end
   endgenerate

   always_comb begin
      next_dir = dir;
      next_odrain = odrain;
      next_dout = dout;
      next_altsel = altsel;
      if (wr_dir) begin
         next_dir = wdata_i[NUM_PINS-1:0]; // R1
      end
      if (wr_odrain) begin
         next_odrain = wdata_i[NUM_PINS-1:0]; // R2
      end
      if (wr_dout) begin
         next_dout = wdata_i[NUM_PINS-1:0];
      end
      if (wr_altsel) begin
         next_altsel = wdata_i[SEL_W-1:0] & sel_mask; // R3
      end
   end

   always_comb begin
      next_rdata = '0;
      if (rd_i) begin
         case (addr_i)
            OFS_DIR: next_rdata[NUM_PINS-1:0] = dir;
            OFS_ODRAIN: next_rdata[NUM_PINS-1:0] = odrain;
            OFS_DOUT: next_rdata[NUM_PINS-1:0] = dout;
            OFS_PIN: next_rdata[NUM_PINS-1:0] = pin_in; // R6
            OFS_ALTSEL: next_rdata[SEL_W-1:0] = altsel;
            OFS_CLKDIV: next_rdata[CLKDIV_W-1:0] = clkdiv;
            OFS_PWM_PERIOD: next_rdata[PWM_W-1:0] = pwm_period;
            OFS_PWM_DUTY: next_rdata[PWM_W-1:0] = pwm_duty;
            OFS_EDGE: next_rdata[NUM_PINS-1:0] = edge_flag;
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dir <= DIR_RST[NUM_PINS-1:0]; // R4
         odrain <= ODRAIN_RST[NUM_PINS-1:0];
         dout <= DOUT_RST[NUM_PINS-1:0];
         altsel <= ALTSEL_RST[SEL_W-1:0]; // R5
         edge_flag <= EDGE_RST[NUM_PINS-1:0]; // R5
         rdata_o <= '0;
      end else begin
         dir <= next_dir;
         odrain <= next_odrain;
         dout <= next_dout;
         altsel <= next_altsel;
         edge_flag <= next_edge_flag;
         rdata_o <= next_rdata;
      end
   end

   // A divider or period write restarts its counter from zero.
   always_comb begin
      next_clkdiv = clkdiv;
      next_clk_cnt = clk_cnt + 1'b1;
      next_gpclk = gpclk;
      if (clk_cnt >= clkdiv) begin
         next_clk_cnt = '0;
         next_gpclk = ~gpclk;
      end
      if (wr_clkdiv) begin
         next_clkdiv = wdata_i[CLKDIV_W-1:0];
         next_clk_cnt = '0;
         next_gpclk = 1'b0;
      end
   end

   always_comb begin
      next_pwm_period = pwm_period;
      next_pwm_duty = pwm_duty;
      next_pwm_cnt = pwm_cnt + 1'b1;
      if (pwm_cnt >= pwm_period) begin
         next_pwm_cnt = '0;
      end
      if (wr_period) begin
         next_pwm_period = wdata_i[PWM_W-1:0];
         next_pwm_cnt = '0;
      end
      if (wr_duty) begin
         next_pwm_duty = wdata_i[PWM_W-1:0];
      end
      next_pwm = next_pwm_cnt < next_pwm_duty;
   end

   // These generators are deliberately left out of reset.
   always_ff @(posedge clk_i) begin
      clkdiv <= next_clkdiv; // R5
      clk_cnt <= next_clk_cnt;
      gpclk <= next_gpclk;
      pwm_period <= next_pwm_period; // R5
      pwm_duty <= next_pwm_duty;
      pwm_cnt <= next_pwm_cnt;
      pwm <= next_pwm;
   end

   property p_reset_inputs;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> pad_oe_o == '0 && dir == '0;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) // R4
      else $error("Pin driven right after reset.");

   property p_dir_write;
      @(posedge clk_i) disable iff (rst_i)
      wr_dir ##1 !wr_dir && !wr_odrain && !wr_altsel |=>
         pad_oe_o[0] == ($past(dir[0], 1) && !$past(odrain[0], 1)) ||
         $past(odrain[0], 1);
   endproperty
   a_dir_write: assert property (p_dir_write) // R1
      else $error("Direction write not applied to driver.");

   property p_dir_store;
      @(posedge clk_i) disable iff (rst_i)
      wr_dir |=> dir == $past(wdata_i[NUM_PINS-1:0]);
   endproperty
   a_dir_store: assert property (p_dir_store) // R1
      else $error("Direction register did not take the write.");

   property p_odrain_store;
      @(posedge clk_i) disable iff (rst_i)
      wr_odrain |=> odrain == $past(wdata_i[NUM_PINS-1:0]);
   endproperty
   a_odrain_store: assert property (p_odrain_store) // R2
      else $error("Drive mode register did not take the write.");

   property p_alt_capable;
      @(posedge clk_i) disable iff (rst_i)
      (altsel & ~sel_mask) == '0;
   endproperty
   a_alt_capable: assert property (p_alt_capable) // R3
      else $error("Alternative selected on a pin that has none.");

   property p_edge_sticky;
      @(posedge clk_i) disable iff (rst_i)
      edge_flag[0] && !(wr_edge && wdata_i[0]) |=> edge_flag[0];
   endproperty
   a_edge_sticky: assert property (p_edge_sticky) // R3
      else $error("Edge flag lost without a clear.");

   property p_alt_reset;
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> altsel == '0 && edge_flag == '0;
   endproperty
   a_alt_reset: assert property (p_alt_reset) // R5
      else $error("Alternative function state survived reset.");

   property p_gen_kept;
      @(posedge clk_i)
      rst_i && $past(rst_i) && !$past(wr_i) |->
         $stable(clkdiv) && $stable(pwm_period) && $stable(pwm_duty);
   endproperty
   a_gen_kept: assert property (p_gen_kept) // R5
      else $error("Clock or PWM setting lost in reset.");

   property p_clkdiv_store;
      @(posedge clk_i) disable iff (rst_i)
      wr_clkdiv |=> clkdiv == $past(wdata_i[CLKDIV_W-1:0]) && !gpclk;
   endproperty
   a_clkdiv_store: assert property (p_clkdiv_store) // R3
      else $error("Clock divider write not applied.");

   property p_duty_store;
      @(posedge clk_i) disable iff (rst_i)
      wr_duty |=> pwm_duty == $past(wdata_i[PWM_W-1:0]);
   endproperty
   a_duty_store: assert property (p_duty_store) // R3
      else $error("PWM duty write not applied.");

   property p_pin_read;
      @(posedge clk_i) disable iff (rst_i)
      rd_i && addr_i == OFS_PIN |=> rdata_o[NUM_PINS-1:0] == $past(pin_in);
   endproperty
   a_pin_read: assert property (p_pin_read) // R6
      else $error("Pin level read back wrong.");

endmodule

// ### dv/gpio_board.sv
// Board model of the port pins: pull-ups and external drivers.
`timescale 1ns/100ps
module gpio_board #(
   parameter int N = 9
)
(
   input wire logic [N-1:0] pad_out_i,
   input wire logic [N-1:0] pad_oe_i,
   input wire logic [N-1:0] ext_val_i,
   input wire logic [N-1:0] ext_en_i,
   output logic [N-1:0] level_o
);
   // A pin nobody drives is held high by its pull-up.
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (pad_oe_i[i]) begin
            level_o[i] = pad_out_i[i];
         end else if (ext_en_i[i]) begin
            level_o[i] = ext_val_i[i];
         end else begin
            level_o[i] = 1'b1;
         end
      end
   end
endmodule

// ### dv/gpio_port_tb.sv
// Self-checking testbench of the general-purpose port.
`timescale 1ns/100ps
module gpio_port_tb
   import gpio_port_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [8:0] pad_in;
   logic [8:0] pad_out;
   logic [8:0] pad_oe;
   logic [8:0] ext_val = 9'h000;
   logic [8:0] ext_en = 9'h000;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   int hi;
   int tg;

   always #20 clk = ~clk;

   gpio_port dut (
      .clk_i(clk),
      .rst_i(rst),
      .addr_i(addr),
      .wdata_i(wdata),
      .wr_i(wr),
      .rd_i(rd),
      .rdata_o(rdata),
      .pad_in_i(pad_in),
      .pad_out_o(pad_out),
      .pad_oe_o(pad_oe)
   );

   gpio_board board (
      .pad_out_i(pad_out),
      .pad_oe_i(pad_oe),
      .ext_val_i(ext_val),
      .ext_en_i(ext_en),
      .level_o(pad_in)
   );

   task automatic summarize;
      $display("Comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rchk(input string name, input logic [3:0] a,
                       input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask

   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic watch(input int pin);
      logic prev;
      hi = 0;
      tg = 0;
      @(posedge clk);
      #1;
      prev = pad_out[pin];
      repeat (8) begin
         @(posedge clk);
         #1;
         hi += int'(pad_out[pin]);
         tg += int'(pad_out[pin] != prev);
         prev = pad_out[pin];
      end
   endtask

   task automatic t_reset;
      #1;
      chk("oe", 32'h0, {23'h0, pad_oe});
      chk("out", 32'h0, {23'h0, pad_out});
      rchk("dir", OFS_DIR, DIR_RST);
      rchk("odrain", OFS_ODRAIN, ODRAIN_RST);
      rchk("dout", OFS_DOUT, DOUT_RST);
      rchk("altsel", OFS_ALTSEL, ALTSEL_RST);
      rchk("edge", OFS_EDGE, EDGE_RST);
      rchk("unmapped", 4'hF, 32'h0);
   endtask

   task automatic t_dir;
      for (int i = 0; i < 9; i++) begin
         wreg(OFS_DIR, 32'h1 << i);
         settle();
         chk("oe one", 32'h1 << i, {23'h0, pad_oe});
      end
   endtask

   task automatic t_drive;
      wreg(OFS_DIR, 32'h1FF);
      wreg(OFS_DOUT, 32'h0AA);
      settle();
      chk("pp oe", 32'h1FF, {23'h0, pad_oe});
      chk("pp out", 32'h0AA, {23'h0, pad_out});
      wreg(OFS_ODRAIN, 32'h1FF);
      settle();
      chk("od oe", 32'h155, {23'h0, pad_oe});
      chk("od low", 32'h0, {23'h0, pad_out & pad_oe});
      rchk("od pin", OFS_PIN, 32'h0AA);
      @(posedge clk);
      #1;
      chk("rdata idle", 32'h0, rdata);
      wreg(OFS_DIR, 32'h0);
      ext_en <= 9'h1FF;
      ext_val <= 9'h123;
      wreg(OFS_PIN, 32'h0);
      settle();
      chk("in oe", 32'h0, {23'h0, pad_oe});
      rchk("in pin", OFS_PIN, 32'h123);
      ext_en <= 9'h000;
      wreg(OFS_ODRAIN, 32'h0);
   endtask

   task automatic t_alt;
      wreg(OFS_ALTSEL, 32'hFFFF_FFFF);
      rchk("alt mask", OFS_ALTSEL, 32'h0003_FF00);
      wreg(OFS_ALTSEL, 32'h0000_0300);
      wreg(OFS_EDGE, 32'h1FF);
      ext_val <= 9'h000;
      ext_en <= 9'h010;
      settle();
      rchk("edge idle", OFS_EDGE, 32'h0);
      ext_val <= 9'h010;
      settle();
      rchk("edge set", OFS_EDGE, 32'h10);
      wreg(OFS_EDGE, 32'h10);
      rchk("edge clr", OFS_EDGE, 32'h0);
      ext_en <= 9'h000;
   endtask

   task automatic t_timers;
      wreg(OFS_CLKDIV, 32'h1);
      wreg(OFS_PWM_PERIOD, 32'h3);
      wreg(OFS_PWM_DUTY, 32'h1);
      for (int k = 0; k < 2; k++) begin
         wreg(OFS_ALTSEL, 32'h0000_0900);
         wreg(OFS_DIR, 32'h030);
         settle();
         watch(4);
         chk("gpclk toggles", 32'd4, tg);
         watch(5);
         chk("pwm high", 32'd2, hi);
         do_reset();
         #1;
         chk("rst oe", 32'h0, {23'h0, pad_oe});
         rchk("rst alt", OFS_ALTSEL, 32'h0);
         rchk("rst clkdiv", OFS_CLKDIV, 32'h1);
         rchk("rst period", OFS_PWM_PERIOD, 32'h3);
         rchk("rst duty", OFS_PWM_DUTY, 32'h1);
      end
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_dir();
      t_drive();
      t_alt();
      t_timers();
      summarize();
   end
endmodule
